// ==== rtl/gcid_img_if.sv ====
`timescale 1ns/1ns
interface gcid_img_if;
	logic       start;
	logic       busy;
	logic       done;
	logic       byte_valid;
	logic [7:0] byte_addr;
	logic [7:0] byte_data;
	modport reader (input start, output busy, output done, output byte_valid,
		output byte_addr, output byte_data);
	modport sink (output start, input busy, input done, input byte_valid,
		input byte_addr, input byte_data);
endinterface

// ==== rtl/gcid_learner.sv ====
`timescale 1ns/1ns
module gcid_learner (
	input  wire logic        clk,
	input  wire logic        resetn,
	input  wire logic        enable,
	input  wire logic        load,
	input  wire logic [15:0] load_value,
	input  wire logic [15:0] remaining_charge,
	input  wire logic [15:0] discharged_amount,
	input  wire logic [15:0] battery_mv,
	input  wire logic [15:0] first_end_mv,
	input  wire logic        discharging,
	output logic [15:0]      learned_full_capacity
);
	logic armed;
	logic hit_end;

	assign hit_end = enable && armed && discharging && (battery_mv <= first_end_mv);

	// a discharge only qualifies if it started from a full gauge
	always_ff @(posedge clk)
	begin
		if (!resetn)
			armed <= 1'b0;
		else if (load || !discharging || hit_end)
			armed <= 1'b0;
		else if (enable && remaining_charge == learned_full_capacity)
			armed <= 1'b1;
	end

	// image value loads; learned amount replaces it
	always_ff @(posedge clk)
	begin
		if (!resetn)
			learned_full_capacity <= 16'h0000;
		else if (load)
			learned_full_capacity <= load_value;
		else if (hit_end)
			learned_full_capacity <= discharged_amount;
	end

	default clocking cb @(posedge clk); endclocking
	default disable iff (!resetn);

	a_learn_update: assert property (
		(hit_end && !load) |=> learned_full_capacity == $past(discharged_amount))
		else $error("learned capacity not replaced at end threshold");
	a_arm_needs_full: assert property (
		$rose(armed) |-> $past(remaining_charge) == $past(learned_full_capacity) && $past(enable))
		else $error("learning armed without a full gauge");
endmodule // gcid_learner

// ==== rtl/gcid_pkg.sv ====
package gcid_pkg;
	// image layout, byte addresses inside the external memory
	localparam int         IMG_LEN   = 24;
	localparam logic [7:0] IMG_LAST  = 8'h17;
	localparam logic [4:0] A_CAP     = 5'h00;
	localparam logic [4:0] A_VOLT    = 5'h02;
	localparam logic [4:0] A_FCUR    = 5'h04;
	localparam logic [4:0] A_FVOLT   = 5'h06;
	localparam logic [4:0] A_ALARM   = 5'h08;
	localparam logic [4:0] A_OPT1    = 5'h0A;
	localparam logic [4:0] A_OPT2    = 5'h0B;
	localparam logic [4:0] A_CGAIN   = 5'h0C;
	localparam logic [4:0] A_FIRST_END_VOLTAGE    = 5'h0E;
	localparam logic [4:0] A_FINAL_END_VOLTAGE    = 5'h10;
	localparam logic [4:0] A_TOFS    = 5'h12;
	localparam logic [4:0] A_TLIM    = 5'h13;
	localparam logic [4:0] A_SDR     = 5'h14;
	localparam logic [4:0] A_FILT    = 5'h15;
	localparam logic [4:0] A_IGAIN   = 5'h16;
	// register byte offsets on the bus
	localparam logic [7:0] R_CTRL    = 8'h00;
	localparam logic [7:0] R_DCAP    = 8'h04;
	localparam logic [7:0] R_FCAP    = 8'h08;
	localparam logic [7:0] R_VOLT    = 8'h0C;
	localparam logic [7:0] R_FCUR    = 8'h10;
	localparam logic [7:0] R_FVOLT   = 8'h14;
	localparam logic [7:0] R_ALARM   = 8'h18;
	localparam logic [7:0] R_OPT     = 8'h1C;
	localparam logic [7:0] R_CGAIN   = 8'h20;
	localparam logic [7:0] R_EDV     = 8'h24;
	localparam logic [7:0] R_TEMP    = 8'h28;
	localparam logic [7:0] R_TLIM    = 8'h2C;
	localparam logic [7:0] R_SDR     = 8'h30;
	localparam logic [7:0] R_FILT    = 8'h34;
	localparam logic [7:0] R_IGAIN   = 8'h38;
	localparam logic [7:0] R_CURR    = 8'h3C;
	// field positions
	localparam int         CTRL_RELOAD_BIT = 0;
	localparam int         CTRL_BUSY_BIT   = 1;
	localparam int         CTRL_LOADED_BIT = 2;
	localparam int         HOST_WRITE_INHIBIT_BIT       = 4;
	// reset values before the image arrives
	localparam logic [7:0] TOFS_DEFAULT = 8'h80;
	localparam logic [7:0] OPT1_RESET   = 8'h10;
	localparam logic [7:0] OPT2_RESET   = 8'h90;
	// temperature limits in 0.1 degree units
	localparam logic [15:0] MAXT_BASE   = 16'h02E4;
	localparam logic [15:0] MAXT_STEP   = 16'h0010;
	localparam logic [15:0] RISE_BASE   = 16'h0010;
	localparam logic [15:0] RISE_MUL    = 16'h0002;
endpackage

// ==== rtl/gcid_reader.sv ====
`timescale 1ns/1ns
module gcid_reader (
	input  wire logic       clk,
	input  wire logic       resetn,
	gcid_img_if.reader      img,
	output logic            mem_req,
	output logic [7:0]      mem_addr,
	input  wire logic       mem_ack,
	input  wire logic [7:0] mem_data
);
	typedef enum logic {ST_IDLE, ST_FETCH} gcid_rd_state_t;
	gcid_rd_state_t state;
	logic           last_ack;

	assign last_ack = (state == ST_FETCH) && mem_ack && (mem_addr == gcid_pkg::IMG_LAST);
	assign img.busy = (state == ST_FETCH);
	assign img.byte_valid = (state == ST_FETCH) && mem_ack;
	assign img.byte_addr = mem_addr;
	assign img.byte_data = mem_data;

	always_ff @(posedge clk)
	begin
		if (!resetn)
		begin
			state <= ST_IDLE;
			mem_req <= 1'b0;
			mem_addr <= 8'h00;
		end
		else
		begin
			case (state)
				ST_IDLE:
					if (img.start)
					begin
						state <= ST_FETCH;
						mem_req <= 1'b1;
						mem_addr <= 8'h00;
					end
				ST_FETCH:
					if (last_ack)
					begin
						state <= ST_IDLE;
						mem_req <= 1'b0;
					end
					else if (mem_ack)
						mem_addr <= mem_addr + 8'h01;
				default:
					state <= ST_IDLE;
			endcase
		end
	end

	// one done pulse after the last byte
	always_ff @(posedge clk)
	begin
		if (!resetn)
			img.done <= 1'b0;
		else
			img.done <= last_ack;
	end

	default clocking cb @(posedge clk); endclocking
	default disable iff (!resetn);

	a_fetch_order: assert property (
		(img.byte_valid && mem_addr != gcid_pkg::IMG_LAST)
			|=> mem_req && mem_addr == $past(mem_addr) + 8'h01)
		else $error("image bytes not fetched in ascending order");
	a_done_last: assert property (
		last_ack |=> img.done && !mem_req ##1 !img.done)
		else $error("done pulse wrong after last byte");
endmodule // gcid_reader

// ==== rtl/gcid_top.sv ====
// How it works
// - full capacity starts from the design capacity word at bytes 00/01.
// - valid full-to-first-threshold discharge replaces full capacity with measured amount.
// - reported voltage at reset comes from the word at bytes 02/03.
// - fast charge current request comes from bytes 04/05.
// - fast charge voltage request comes from bytes 06/07.
// - low capacity alarm threshold loads from bytes 08/09.
// - primary option byte at 0A; its inhibit bit blocks host writes to the alarm threshold.
// - secondary option byte loads from byte 0B.
// - current measurement gain word loads from bytes 0C/0D.
// - end thresholds at 0E and 10 are stored negated; negate back.
// - temperature offset at 12 is subtracted from nominal temperature.
// - byte 13 gives maximum charge temperature and rise step.
// - byte 14 is the negated self-discharge divisor.
// - byte 15 sets the magnitude filter on sense values.
// - integration gain at 16/17 scales sensed voltage into current.
//
// The placing of the registers and the AHB-Lite interface to the registers were left to the implementer.
`timescale 1ns/1ns
module gcid_top #(
	parameter int SCALE_SHIFT = 6
) (
	input  wire logic        clk,
	input  wire logic        resetn,
	input  wire logic        hsel,
	input  wire logic [31:0] haddr,
	input  wire logic [1:0]  htrans,
	input  wire logic        hwrite,
	input  wire logic [2:0]  hsize,
	input  wire logic [31:0] hwdata,
	input  wire logic        hready,
	output logic [31:0]      hrdata,
	output logic             hreadyout,
	output logic             hresp,
	output logic             mem_req,
	output logic [7:0]       mem_addr,
	input  wire logic        mem_ack,
	input  wire logic [7:0]  mem_data,
	input  wire logic [15:0] remaining_charge,
	input  wire logic [15:0] discharged_amount,
	input  wire logic [15:0] battery_mv,
	input  wire logic        discharging,
	input  wire logic [15:0] nominal_temp,
	input  wire logic [15:0] sense_resistor_input,
	output logic [15:0]      learned_full_capacity,
	output logic [15:0]      reported_voltage,
	output logic [15:0]      charge_current_request,
	output logic [15:0]      charge_voltage_request,
	output logic             host_write_inhibit,
	output logic             image_loaded,
	output logic             low_capacity_alarm,
	output logic [15:0]      corrected_temp,
	output logic [15:0]      current_ma
);
	gcid_img_if img ();

	logic [7:0]         image [0:gcid_pkg::IMG_LEN-1];
	logic [15:0]        design_cap;
	logic [15:0]        alarm_threshold;
	logic [7:0]         primary_option_byte;
	logic [7:0]         secondary_option_byte;
	logic [15:0]        meas_gain;
	logic [15:0]        first_end_voltage;
	logic [15:0]        final_end_voltage;
	logic [7:0]         temp_offset;
	logic [7:0]         temp_limits;
	logic [7:0]         self_disch;
	logic [7:0]         filter_level;
	logic [15:0]        integ_gain;
	logic [15:0]        max_charge_temp;
	logic [15:0]        rise_step;
	logic [7:0]         self_disch_div;
	logic signed [15:0] sense;
	logic [15:0]        sense_mag;
	logic signed [15:0] filtered;
	logic signed [32:0] product;
	logic               start_q;
	logic               pend;
	logic               a_write;
	logic               a_hit;
	logic [7:0]         a_addr;
	logic               accept;
	logic               stall;
	logic               commit;
	logic               wr_commit;
	logic [31:0]        rdata;

	function automatic logic [15:0] word16(input logic [4:0] a);
		// low byte at the lower address
		return {image[a + 5'h01], image[a]};
	endfunction

	gcid_reader u_reader (
		.clk      (clk),
		.resetn   (resetn),
		.img      (img),
		.mem_req  (mem_req),
		.mem_addr (mem_addr),
		.mem_ack  (mem_ack),
		.mem_data (mem_data)
	);

	gcid_learner u_learner (
		.clk                   (clk),
		.resetn                (resetn),
		.enable                (image_loaded),
		.load                  (img.done),
		.load_value            (word16(gcid_pkg::A_CAP)),
		.remaining_charge      (remaining_charge),
		.discharged_amount     (discharged_amount),
		.battery_mv            (battery_mv),
		.first_end_mv          (first_end_voltage),
		.discharging           (discharging),
		.learned_full_capacity (learned_full_capacity)
	);

	assign img.start = start_q;

	// fetch starts on the first edge after reset, or on a reload
	always_ff @(posedge clk)
	begin
		if (!resetn)
			start_q <= 1'b1;
		else
			start_q <= wr_commit && a_addr == gcid_pkg::R_CTRL
				&& hwdata[gcid_pkg::CTRL_RELOAD_BIT] && !img.busy;
	end

	always_ff @(posedge clk)
	begin
		if (img.byte_valid)
			image[img.byte_addr[4:0]] <= img.byte_data;
	end

	// loaded flag gates gauging and dependent bus answers
	always_ff @(posedge clk)
	begin
		if (!resetn)
			image_loaded <= 1'b0;
		else if (img.done)
			image_loaded <= 1'b1;
		else if (start_q)
			image_loaded <= 1'b0;
	end

	// words copied when the image completes
	always_ff @(posedge clk)
	begin
		if (!resetn)
		begin
			design_cap <= 16'h0000;
			reported_voltage <= 16'h0000;
			charge_current_request <= 16'h0000;
			charge_voltage_request <= 16'h0000;
			secondary_option_byte <= gcid_pkg::OPT2_RESET;
			meas_gain <= 16'h0000;
		end
		else if (img.done)
		begin
			design_cap <= word16(gcid_pkg::A_CAP);
			reported_voltage <= word16(gcid_pkg::A_VOLT);
			charge_current_request <= word16(gcid_pkg::A_FCUR);
			charge_voltage_request <= word16(gcid_pkg::A_FVOLT);
			secondary_option_byte <= image[gcid_pkg::A_OPT2];
			meas_gain <= word16(gcid_pkg::A_CGAIN);
		end
	end

	// inhibit bit defaults set so the alarm threshold is not writable before the image
	always_ff @(posedge clk)
	begin
		if (!resetn)
		begin
			primary_option_byte <= gcid_pkg::OPT1_RESET;
			host_write_inhibit <= gcid_pkg::OPT1_RESET[gcid_pkg::HOST_WRITE_INHIBIT_BIT];
		end
		else if (img.done)
		begin
			primary_option_byte <= image[gcid_pkg::A_OPT1];
			host_write_inhibit <= image[gcid_pkg::A_OPT1][gcid_pkg::HOST_WRITE_INHIBIT_BIT];
		end
	end

	// alarm loads from the image; host may rewrite it only if not inhibited
	always_ff @(posedge clk)
	begin
		if (!resetn)
			alarm_threshold <= 16'h0000;
		else if (img.done)
			alarm_threshold <= word16(gcid_pkg::A_ALARM);
		else if (wr_commit && a_addr == gcid_pkg::R_ALARM && !host_write_inhibit)
			alarm_threshold <= hwdata[15:0];
	end

	always_ff @(posedge clk)
	begin
		if (!resetn)
		begin
			first_end_voltage <= 16'h0000;
			final_end_voltage <= 16'h0000;
			temp_offset <= gcid_pkg::TOFS_DEFAULT;
			temp_limits <= 8'h00;
			self_disch <= 8'h00;
			filter_level <= 8'h00;
			integ_gain <= 16'h0000;
		end
		else if (img.done)
		begin
			first_end_voltage <= 16'h0000 - word16(gcid_pkg::A_FIRST_END_VOLTAGE);
			final_end_voltage <= 16'h0000 - word16(gcid_pkg::A_FINAL_END_VOLTAGE);
			temp_offset <= image[gcid_pkg::A_TOFS];
			temp_limits <= image[gcid_pkg::A_TLIM];
			self_disch <= image[gcid_pkg::A_SDR];
			filter_level <= image[gcid_pkg::A_FILT];
			integ_gain <= word16(gcid_pkg::A_IGAIN);
		end
	end

	// limits in tenths of a degree
	assign max_charge_temp = gcid_pkg::MAXT_BASE - 16'({12'h000, temp_limits[7:4]} * gcid_pkg::MAXT_STEP);
	assign rise_step = 16'({12'h000, temp_limits[3:0]} * gcid_pkg::RISE_MUL) + gcid_pkg::RISE_BASE;
	// negating gives 52.73 divided by the rate
	assign self_disch_div = 8'h00 - self_disch;

	// magnitudes under the filter level are treated as zero
	assign sense = $signed(sense_resistor_input);
	assign sense_mag = sense[15] ? 16'h0000 - sense_resistor_input : sense_resistor_input;
	assign filtered = (sense_mag < {8'h00, filter_level}) ? 16'sh0000 : sense;
	// scaled by integration gain, fixed-point shift is a parameter
	assign product = filtered * $signed({1'b0, integ_gain});

	// gauging outputs held at zero until the image is in
	always_ff @(posedge clk)
	begin
		if (!resetn || !image_loaded)
		begin
			corrected_temp <= 16'h0000;
			current_ma <= 16'h0000;
			low_capacity_alarm <= 1'b0;
		end
		else
		begin
			corrected_temp <= nominal_temp - {8'h00, temp_offset};
			current_ma <= product[SCALE_SHIFT +: 16];
			low_capacity_alarm <= remaining_charge < alarm_threshold;
		end
	end

	// bus slave: every transfer takes at least one wait state so hrdata comes from a flop
	assign accept = hsel && hready && htrans[1];
	// dependent accesses wait while the image is still being read
	assign stall = pend && !image_loaded && a_addr != gcid_pkg::R_CTRL;
	assign commit = pend && !stall;
	assign wr_commit = commit && a_write && a_hit;

	always_ff @(posedge clk)
	begin
		if (!resetn)
		begin
			pend <= 1'b0;
			a_write <= 1'b0;
			a_hit <= 1'b0;
			a_addr <= 8'h00;
			hreadyout <= 1'b1;
			hresp <= 1'b0;
		end
		else if (accept)
		begin
			pend <= 1'b1;
			a_write <= hwrite;
			a_hit <= haddr[31:8] == 24'h000000 && haddr[1:0] == 2'h0;
			a_addr <= haddr[7:0];
			hreadyout <= 1'b0;
		end
		else if (commit)
		begin
			pend <= 1'b0;
			hreadyout <= 1'b1;
		end
	end

	always_comb
	begin
		rdata = 32'h00000000;
		if (!a_hit)
			rdata = 32'h00000000;
		else if (a_addr == gcid_pkg::R_CTRL)
		begin
			rdata[gcid_pkg::CTRL_BUSY_BIT] = img.busy;
			rdata[gcid_pkg::CTRL_LOADED_BIT] = image_loaded;
		end
		else if (a_addr == gcid_pkg::R_DCAP)
			rdata = {16'h0000, design_cap};
		else if (a_addr == gcid_pkg::R_FCAP)
			rdata = {16'h0000, learned_full_capacity};
		else if (a_addr == gcid_pkg::R_VOLT)
			rdata = {16'h0000, reported_voltage};
		else if (a_addr == gcid_pkg::R_FCUR)
			rdata = {16'h0000, charge_current_request};
		else if (a_addr == gcid_pkg::R_FVOLT)
			rdata = {16'h0000, charge_voltage_request};
		else if (a_addr == gcid_pkg::R_ALARM)
			rdata = {16'h0000, alarm_threshold};
		else if (a_addr == gcid_pkg::R_OPT)
			rdata = {16'h0000, secondary_option_byte, primary_option_byte};
		else if (a_addr == gcid_pkg::R_CGAIN)
			rdata = {16'h0000, meas_gain};
		else if (a_addr == gcid_pkg::R_EDV)
			rdata = {final_end_voltage, first_end_voltage};
		else if (a_addr == gcid_pkg::R_TEMP)
			rdata = {corrected_temp, 8'h00, temp_offset};
		else if (a_addr == gcid_pkg::R_TLIM)
			rdata = {rise_step, max_charge_temp};
		else if (a_addr == gcid_pkg::R_SDR)
			rdata = {16'h0000, self_disch_div, self_disch};
		else if (a_addr == gcid_pkg::R_FILT)
			rdata = {24'h000000, filter_level};
		else if (a_addr == gcid_pkg::R_IGAIN)
			rdata = {16'h0000, integ_gain};
		else if (a_addr == gcid_pkg::R_CURR)
			rdata = {16'h0000, current_ma};
	end

	always_ff @(posedge clk)
	begin
		if (!resetn)
			hrdata <= 32'h00000000;
		else if (commit && !a_write)
			hrdata <= rdata;
	end

	default clocking cb @(posedge clk); endclocking
	default disable iff (!resetn);

	sequence s_image_done;
		img.done;
	endsequence

	sequence s_dependent_wait;
		pend && !image_loaded && a_addr != gcid_pkg::R_CTRL;
	endsequence

	a_cap_init: assert property (
		s_image_done |=> learned_full_capacity == design_cap
			&& design_cap == {$past(image[1]), $past(image[0])})
		else $error("full capacity not taken from design capacity");
	a_volt_load: assert property (
		s_image_done |=> reported_voltage == {$past(image[3]), $past(image[2])})
		else $error("reported voltage not taken from image");
	a_charge_req: assert property (
		s_image_done |=> charge_current_request == {$past(image[5]), $past(image[4])}
			&& charge_voltage_request == {$past(image[7]), $past(image[6])})
		else $error("charge requests not assembled low byte first");
	a_inhibit_hold: assert property (
		(wr_commit && a_addr == gcid_pkg::R_ALARM && host_write_inhibit && !img.done)
			|=> $stable(alarm_threshold))
		else $error("host write passed while inhibited");
	a_opt2_load: assert property (
		s_image_done |=> secondary_option_byte == $past(image[11]))
		else $error("secondary option byte not loaded");
	a_edv_negate: assert property (
		s_image_done |=> 16'(first_end_voltage + {$past(image[15]), $past(image[14])}) == 16'h0000)
		else $error("first end threshold not negated");
	a_temp_offset: assert property (
		(image_loaded && !img.done && !start_q)
			|=> corrected_temp == $past(nominal_temp) - {8'h00, $past(temp_offset)})
		else $error("temperature offset not subtracted");
	a_maxt_calc: assert property (
		s_image_done |=> temp_limits == $past(image[19])
			&& 16'(max_charge_temp + {8'h00, temp_limits[7:4], 4'h0}) == gcid_pkg::MAXT_BASE
			&& 16'(rise_step - {11'h000, temp_limits[3:0], 1'b0}) == gcid_pkg::RISE_BASE)
		else $error("temperature limits miscomputed");
	a_wait_unloaded: assert property (
		s_dependent_wait |=> !hreadyout)
		else $error("dependent access answered before image loaded");
endmodule // gcid_top

// ==== verification/gcid_mem_model.sv ====
`timescale 1ns/1ns
module gcid_mem_model (
	input  wire logic       clk,
	input  wire logic       mem_req,
	input  wire logic [7:0] mem_addr,
	output logic            mem_ack,
	output logic [7:0]      mem_data
);
	logic [7:0] img [24] = '{8'h08, 8'h07, 8'h30, 8'h2A, 8'h08, 8'h07, 8'hC4, 8'h3B,
		8'hB4, 8'h00, 8'h10, 8'h90, 8'hEE, 8'h02, 8'h16, 8'hDB,
		8'hD8, 8'hDC, 8'h32, 8'h87, 8'hDD, 8'h96, 8'h40, 8'h00};
	int         slow = 0;
	int         cnt  = 0;

	initial
	begin
		mem_ack = 1'b0;
		mem_data = 8'h00;
	end

	// answers after slow idle cycles; data toggles when not answering so stale bytes never match
	// plain always: the bench rewrites img and slow between loads
	always @(posedge clk)
	begin
		if (mem_req && !mem_ack && cnt >= slow)
		begin
			mem_ack <= 1'b1;
			mem_data <= img[mem_addr[4:0]];
			cnt <= 0;
		end
		else
		begin
			mem_ack <= 1'b0;
			mem_data <= ~mem_data;
			if (mem_req)
				cnt <= cnt + 1;
		end
	end
endmodule // gcid_mem_model

// ==== verification/testbench.sv ====
`timescale 1ns/1ns
module testbench;
	logic        clk = 0;
	logic        resetn = 0;
	logic        hsel = 0;
	logic [31:0] haddr = 32'h0;
	logic [1:0]  htrans = 2'h0;
	logic        hwrite = 0;
	logic [31:0] hwdata = 32'h0;
	logic [31:0] hrdata;
	logic        hreadyout;
	logic        hresp;
	logic        mem_req;
	logic [7:0]  mem_addr;
	logic        mem_ack;
	logic [7:0]  mem_data;
	logic [15:0] remaining_charge = 16'h0;
	logic [15:0] discharged_amount = 16'h0;
	logic [15:0] battery_mv = 16'h2710;
	logic        discharging = 0;
	logic [15:0] nominal_temp = 16'h00C8;
	logic [15:0] sense_resistor_input = 16'h0;
	logic [15:0] lfc, rep_v, cc_req, cv_req, c_temp, cur_ma;
	logic        hwi, loaded, alarm;
	logic [31:0] rd;
	logic [31:0] m;
	int          bad_count = 0;
	int          n_tests = 0;
	logic [7:0]  ra [16] = '{8'h00, 8'h04, 8'h08, 8'h0C, 8'h10, 8'h14, 8'h18, 8'h1C,
		8'h20, 8'h24, 8'h28, 8'h2C, 8'h30, 8'h34, 8'h38, 8'h40};
	logic [31:0] rx [16] = '{32'h4, 32'h708, 32'h708, 32'h2A30,
		32'h708, 32'h3BC4, 32'hB4, 32'h9010, 32'h2EE,
		32'h232824EA, 32'h32, 32'h1E0264, 32'hDD,
		32'h96, 32'h40, 32'h0};

	always #25 clk = ~clk;

	gcid_mem_model mem (.clk(clk), .mem_req(mem_req), .mem_addr(mem_addr),
		.mem_ack(mem_ack), .mem_data(mem_data));

	gcid_top #(.SCALE_SHIFT(6)) dut (.clk(clk), .resetn(resetn), .hsel(hsel),
		.haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata),
		.hready(hreadyout), .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
		.mem_req(mem_req), .mem_addr(mem_addr), .mem_ack(mem_ack), .mem_data(mem_data),
		.remaining_charge(remaining_charge), .discharged_amount(discharged_amount),
		.battery_mv(battery_mv), .discharging(discharging), .nominal_temp(nominal_temp),
		.sense_resistor_input(sense_resistor_input), .learned_full_capacity(lfc),
		.reported_voltage(rep_v), .charge_current_request(cc_req),
		.charge_voltage_request(cv_req), .host_write_inhibit(hwi), .image_loaded(loaded),
		.low_capacity_alarm(alarm), .corrected_temp(c_temp), .current_ma(cur_ma));

	task chk(input string n, input logic [31:0] s, input logic [31:0] e);
		n_tests++;
		if (s !== e)
		begin
			bad_count++;
			$display("wrong value %s expected %h seen %h", n, e, s);
		end
	endtask

	task results;
		$display("checks %0d mismatches %0d", n_tests, bad_count);
		if (bad_count == 0 && n_tests > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask

	// stalls are unbounded by the slave, so this count of 4000 cycles bounds a wait
	task rdy;
		int i;
		i = 0;
		do
		begin
			@(posedge clk);
			i++;
		end
		while (hreadyout !== 1'b1 && i < 4000);
		if (i >= 4000)
			chk("hready", 32'h0, 32'h1);
	endtask

	task bus(input logic w, input logic [7:0] a, input logic [31:0] d);
		@(posedge clk);
		hsel <= 1'b1;
		htrans <= 2'h2;
		haddr <= {24'h0, a};
		hwrite <= w;
		rdy;
		hsel <= 1'b0;
		htrans <= 2'h0;
		hwdata <= d;
		rdy;
		rd = hrdata;
	endtask

	task settle(input logic [15:0] r, input logic [15:0] s);
		@(posedge clk);
		remaining_charge <= r;
		sense_resistor_input <= s;
		repeat (4) @(posedge clk);
	endtask

	initial
	begin
		#1000000;
		bad_count++;
		results;
	end

	initial
	begin
		repeat (6) @(posedge clk);
		chk("inhibit_rst", {31'h0, hwi}, 32'h1);
		chk("loaded_rst", {31'h0, loaded}, 32'h0);
		chk("req_rst", {31'h0, mem_req}, 32'h0);
		resetn <= 1'b1;
		bus(1'b0, gcid_pkg::R_DCAP, 32'h0);
		chk("early_dcap", rd, 32'h708);
		$display("reset test done");
		for (int i = 0; i < 16; i++)
		begin
			bus(1'b0, ra[i], 32'h0);
			m = (ra[i] == 8'h00) ? 32'h6 : (ra[i] == 8'h28 || ra[i] == 8'h30) ? 32'hFF : '1;
			chk($sformatf("reg_%h", ra[i]), rd & m, rx[i]);
		end
		bus(1'b0, gcid_pkg::R_SDR, 32'h0);
		chk("sdr_neg", {24'h0, rd[15:8] | rd[23:16]}, 32'h23);
		chk("hresp", {31'h0, hresp}, 32'h0);
		bus(1'b0, 8'h1A, 32'h0);
		chk("unaligned", rd, 32'h0);
		$display("register rows done");
		chk("volt", {16'h0, rep_v}, 32'h2A30);
		chk("ccur", {16'h0, cc_req}, 32'h708);
		chk("cvolt", {16'h0, cv_req}, 32'h3BC4);
		chk("ctemp", {16'h0, c_temp}, 32'h96);
		settle(16'h00B3, 16'h0100);
		chk("alarm_lo", {31'h0, alarm}, 32'h1);
		chk("cur_on", {16'h0, cur_ma}, 32'h100);
		bus(1'b0, gcid_pkg::R_CURR, 32'h0);
		chk("curr_reg", rd, 32'h100);
		settle(16'h00B4, 16'h0050);
		chk("alarm_eq", {31'h0, alarm}, 32'h0);
		chk("cur_filt", {16'h0, cur_ma}, 32'h0);
		$display("gauge test done");
		discharged_amount <= 16'h0700;
		discharging <= 1'b1;
		settle(16'h0708, 16'h0);
		chk("cap_hold", {16'h0, lfc}, 32'h708);
		battery_mv <= 16'h24EA;
		repeat (4) @(posedge clk);
		chk("cap_learn", {16'h0, lfc}, 32'h700);
		discharging <= 1'b0;
		$display("learning test done");
		bus(1'b1, gcid_pkg::R_ALARM, 32'h1234);
		bus(1'b0, gcid_pkg::R_ALARM, 32'h0);
		chk("alarm_inh", rd, 32'hB4);
		mem.img[10] = 8'h00;
		mem.img[4] = 8'h11;
		mem.slow = 3;
		bus(1'b1, gcid_pkg::R_CTRL, 32'h1);
		bus(1'b0, gcid_pkg::R_FCUR, 32'h0);
		chk("reload_fcur", rd, 32'h711);
		chk("reload_cap", {16'h0, lfc}, 32'h708);
		chk("inhibit_off", {31'h0, hwi}, 32'h0);
		bus(1'b1, gcid_pkg::R_ALARM, 32'h1234);
		bus(1'b0, gcid_pkg::R_ALARM, 32'h0);
		chk("alarm_wr", rd, 32'h1234);
		$display("reload test done");
		results;
	end
endmodule // testbench
